// [include/urmd_pkg.sv]
// Package: register map constants for the UART register decode block
package urmd_pkg;
  localparam int URMD_AW = 3;
  localparam int URMD_DW = 8;
  localparam logic [2:0] URMD_A_DATA = 3'h0;
  localparam logic [2:0] URMD_A_IEN = 3'h1;
  localparam logic [2:0] URMD_A_ISTAT = 3'h2;
  localparam logic [2:0] URMD_A_LCTL = 3'h3;
  localparam logic [2:0] URMD_A_MCTL = 3'h4;
  localparam logic [2:0] URMD_A_LSTAT = 3'h5;
  localparam logic [2:0] URMD_A_MSTAT = 3'h6;
  localparam logic [2:0] URMD_A_SCR = 3'h7;
  localparam logic [7:0] URMD_PAGE2_KEY = 8'hBF;
  localparam int URMD_LCTL_DLAB = 7;
  localparam int URMD_EFN_ENH = 4;
  localparam logic [7:0] URMD_IEN_ENH_MASK = 8'hF0;
  localparam logic [7:0] URMD_ISTAT_ENH_MASK = 8'h30;
  localparam logic [7:0] URMD_FCTL_ENH_MASK = 8'h30;
  localparam logic [7:0] URMD_MCTL_ENH_MASK = 8'hE0;
  localparam logic [7:0] URMD_MSTAT_ENH_MASK = 8'hF0;
  localparam logic [7:0] URMD_XFEAT_MASK = 8'h3F;
  localparam logic [7:0] URMD_RST_ZERO = 8'h00;
  localparam logic [7:0] URMD_RST_LCTL = 8'h00;
  localparam logic [7:0] URMD_RST_DIV_LOW = 8'h00;
  localparam logic [7:0] URMD_RST_DIV_HIGH = 8'h00;
  localparam logic [7:0] URMD_RST_PULSE_W = 8'h00;
  localparam logic [7:0] URMD_FCTL_SELF_CLR = 8'h06;
endpackage

// [src/urmd_reg8.sv]
// Module: one 8-bit write-masked control register with clock enable
`timescale 1ns/100ps
module urmd_reg8
  import urmd_pkg::*;
#(
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_we,
  input wire logic [7:0] i_keep_mask,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_q
);
  logic [7:0] q_r;
  logic [7:0] q_nxt;
  // Masked bits hold their old value on a write
  assign q_nxt = (q_r & i_keep_mask) | (i_wdata & ~i_keep_mask);
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      q_r <= RESET_VAL;
    end else if (i_ce && i_we) begin
      q_r <= q_nxt;
    end
  end
  assign o_q = q_r;
endmodule

// [src/urmd_top.sv]
// Module: UART register map, address decode and access steering
`timescale 1ns/100ps
module urmd_top
  import urmd_pkg::*;
#(
  parameter logic [7:0] REVISION_CODE = 8'h5A,  // Arbitrary value
  parameter logic [7:0] DEVICE_IDENT = 8'hA5    // Arbitrary value
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic [2:0] i_addr,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  input wire logic [7:0] i_rx_char,
  input wire logic [5:0] i_int_source,
  input wire logic [7:0] i_line_status,
  input wire logic [7:0] i_modem_status,
  output logic o_rx_read,
  output logic o_tx_write,
  output logic [7:0] o_tx_char,
  output logic o_line_status_read,
  output logic o_modem_status_read,
  output logic o_int_status_read,
  output logic [7:0] o_interrupt_enable,
  output logic [7:0] o_fifo_control,
  output logic o_rx_fifo_reset,
  output logic o_tx_fifo_reset,
  output logic [7:0] o_line_control,
  output logic [7:0] o_modem_control,
  output logic [15:0] o_divisor,
  output logic [7:0] o_enhanced_function,
  output logic [7:0] o_extra_feature,
  output logic [7:0] o_ir_pulse_width,
  output logic [7:0] o_resume_char_one,
  output logic [7:0] o_resume_char_two,
  output logic [7:0] o_pause_char_one,
  output logic [7:0] o_pause_char_two
);
  logic [7:0] lctl_q;
  logic [7:0] efn_q;
  logic [7:0] ien_q;
  logic [7:0] mctl_q;
  logic [7:0] div_lo_q;
  logic [7:0] div_hi_q;
  logic [7:0] scr_q;
  logic [7:0] xfeat_q;
  logic [7:0] pwidth_q;
  logic [7:0] res_one_q;
  logic [7:0] res_two_q;
  logic [7:0] pau_one_q;
  logic [7:0] pau_two_q;
  logic [7:0] fctl_r;
  logic [7:0] fctl_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [1:0] fifo_pulse_r;
  logic [7:0] tx_char_r;
  logic tx_write_r;
  logic rx_read_r;
  logic lstat_rd_r;
  logic mstat_rd_r;
  logic istat_rd_r;

  // Decode of the three access pages
  wire page2 = (lctl_q == URMD_PAGE2_KEY);
  wire dlab = lctl_q[URMD_LCTL_DLAB];
  wire base_page = !dlab;
  wire div_page = dlab && !page2;
  wire enh = efn_q[URMD_EFN_ENH];
  wire div_zero = (div_lo_q == URMD_RST_ZERO) && (div_hi_q == URMD_RST_ZERO);
  wire wr_act = i_ce && i_wr;
  wire rd_act = i_ce && i_rd;
  wire a_data = (i_addr == URMD_A_DATA);
  wire a_ien = (i_addr == URMD_A_IEN);
  wire a_istat = (i_addr == URMD_A_ISTAT);
  wire a_lctl = (i_addr == URMD_A_LCTL);
  wire a_mctl = (i_addr == URMD_A_MCTL);
  wire a_lstat = (i_addr == URMD_A_LSTAT);
  wire a_mstat = (i_addr == URMD_A_MSTAT);
  wire a_scr = (i_addr == URMD_A_SCR);

  // Write strobes; page two shadows 010 and 100-111 only
  wire we_tx = i_wr && base_page && a_data;
  wire we_ien = i_wr && base_page && a_ien;
  wire we_fctl = i_wr && base_page && a_istat;
  wire we_lctl = i_wr && a_lctl;
  wire we_mctl = i_wr && base_page && a_mctl;
  wire we_xfeat = i_wr && base_page && a_lstat && enh;
  wire we_pwidth = i_wr && base_page && a_mstat && enh;
  wire we_scr = i_wr && base_page && a_scr;
  wire we_div_lo = i_wr && div_page && a_data;
  wire we_div_hi = i_wr && div_page && a_ien;
  wire we_efn = i_wr && page2 && a_istat;
  wire we_res_one = i_wr && page2 && a_mctl;
  wire we_res_two = i_wr && page2 && a_lstat;
  wire we_pau_one = i_wr && page2 && a_mstat;
  wire we_pau_two = i_wr && page2 && a_scr;

  // Extended bits are frozen while enhanced mode is off
  wire [7:0] ien_keep = enh ? URMD_RST_ZERO : URMD_IEN_ENH_MASK;
  wire [7:0] mctl_keep = enh ? URMD_RST_ZERO : URMD_MCTL_ENH_MASK;

  urmd_reg8 #(.RESET_VAL(URMD_RST_LCTL)) u_lctl (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_we(we_lctl),
    .i_keep_mask(URMD_RST_ZERO),
    .i_wdata(i_wdata),
    .o_q(lctl_q)
  );
  urmd_reg8 #(.RESET_VAL(URMD_RST_ZERO)) u_efn (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_we(we_efn),
    .i_keep_mask(URMD_RST_ZERO),
    .i_wdata(i_wdata),
    .o_q(efn_q)
  );
  urmd_reg8 #(.RESET_VAL(URMD_RST_ZERO)) u_ien (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_we(we_ien),
    .i_keep_mask(ien_keep),
    .i_wdata(i_wdata),
    .o_q(ien_q)
  );
  urmd_reg8 #(.RESET_VAL(URMD_RST_ZERO)) u_mctl (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_we(we_mctl),
    .i_keep_mask(mctl_keep),
    .i_wdata(i_wdata),
    .o_q(mctl_q)
  );
  urmd_reg8 #(.RESET_VAL(URMD_RST_DIV_LOW)) u_div_lo (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_we(we_div_lo),
    .i_keep_mask(URMD_RST_ZERO),
    .i_wdata(i_wdata),
    .o_q(div_lo_q)
  );
  urmd_reg8 #(.RESET_VAL(URMD_RST_DIV_HIGH)) u_div_hi (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_we(we_div_hi),
    .i_keep_mask(URMD_RST_ZERO),
    .i_wdata(i_wdata),
    .o_q(div_hi_q)
  );
  urmd_reg8 #(.RESET_VAL(URMD_RST_ZERO)) u_scr (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_we(we_scr),
    .i_keep_mask(URMD_RST_ZERO),
    .i_wdata(i_wdata),
    .o_q(scr_q)
  );
  // Reserved top bits never take a written one
  urmd_reg8 #(.RESET_VAL(URMD_RST_ZERO)) u_xfeat (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_we(we_xfeat),
    .i_keep_mask(URMD_RST_ZERO),
    .i_wdata(i_wdata & URMD_XFEAT_MASK),
    .o_q(xfeat_q)
  );
  urmd_reg8 #(.RESET_VAL(URMD_RST_PULSE_W)) u_pwidth (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_we(we_pwidth),
    .i_keep_mask(URMD_RST_ZERO),
    .i_wdata(i_wdata),
    .o_q(pwidth_q)
  );
  urmd_reg8 #(.RESET_VAL(URMD_RST_ZERO)) u_res_one (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_we(we_res_one),
    .i_keep_mask(URMD_RST_ZERO),
    .i_wdata(i_wdata),
    .o_q(res_one_q)
  );
  urmd_reg8 #(.RESET_VAL(URMD_RST_ZERO)) u_res_two (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_we(we_res_two),
    .i_keep_mask(URMD_RST_ZERO),
    .i_wdata(i_wdata),
    .o_q(res_two_q)
  );
  urmd_reg8 #(.RESET_VAL(URMD_RST_ZERO)) u_pau_one (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_we(we_pau_one),
    .i_keep_mask(URMD_RST_ZERO),
    .i_wdata(i_wdata),
    .o_q(pau_one_q)
  );
  urmd_reg8 #(.RESET_VAL(URMD_RST_ZERO)) u_pau_two (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_we(we_pau_two),
    .i_keep_mask(URMD_RST_ZERO),
    .i_wdata(i_wdata),
    .o_q(pau_two_q)
  );

  // FIFO control: reset bits are one-shot, stored copy has them cleared
  wire [7:0] fctl_in = enh ? i_wdata : ((i_wdata & ~URMD_FCTL_ENH_MASK) |
    (fctl_r & URMD_FCTL_ENH_MASK));
  assign fctl_nxt = we_fctl ? (fctl_in & ~URMD_FCTL_SELF_CLR) : fctl_r;

  // Read views with gated extended bits forced low
  wire [7:0] ien_view = enh ? ien_q : (ien_q & ~URMD_IEN_ENH_MASK);
  wire [7:0] mctl_view = enh ? mctl_q : (mctl_q & ~URMD_MCTL_ENH_MASK);
  wire [5:0] src_view = enh ? i_int_source : (i_int_source & ~URMD_ISTAT_ENH_MASK[5:0]);
  wire fifo_on = fctl_r[0];
  wire [7:0] istat_view = {fifo_on, fifo_on, src_view};
  wire [7:0] mstat_view = enh ? i_modem_status : (i_modem_status & ~URMD_MSTAT_ENH_MASK);
  wire [7:0] div_lo_view = div_zero ? REVISION_CODE : div_lo_q;
  wire [7:0] div_hi_view = div_zero ? DEVICE_IDENT : div_hi_q;

  // Read mux; write-only locations return the read-only register at the same address
  always_comb begin
    rdata_nxt = URMD_RST_ZERO;
    if (page2 && (a_istat || a_mctl || a_lstat || a_mstat || a_scr)) begin
      unique case (i_addr)
        URMD_A_ISTAT: rdata_nxt = efn_q;
        URMD_A_MCTL: rdata_nxt = res_one_q;
        URMD_A_LSTAT: rdata_nxt = res_two_q;
        URMD_A_MSTAT: rdata_nxt = pau_one_q;
        default: rdata_nxt = pau_two_q;
      endcase
    end else if (dlab && (a_data || a_ien)) begin
      rdata_nxt = a_data ? div_lo_view : div_hi_view;
    end else begin
      unique case (i_addr)
        URMD_A_DATA: rdata_nxt = i_rx_char;
        URMD_A_IEN: rdata_nxt = ien_view;
        URMD_A_ISTAT: rdata_nxt = istat_view;
        URMD_A_LCTL: rdata_nxt = lctl_q;
        URMD_A_MCTL: rdata_nxt = mctl_view;
        URMD_A_LSTAT: rdata_nxt = i_line_status;
        URMD_A_MSTAT: rdata_nxt = mstat_view;
        default: rdata_nxt = scr_q;
      endcase
    end
  end

  // Side effects of accesses to the base page
  wire rd_rx = i_rd && base_page && a_data;
  wire rd_lstat = i_rd && base_page && a_lstat;
  wire rd_mstat = i_rd && base_page && a_mstat;
  wire rd_istat = i_rd && base_page && a_istat;

  // Read data is registered: valid the cycle after a read is taken
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      rdata_r <= URMD_RST_ZERO;
      fctl_r <= URMD_RST_ZERO;
      fifo_pulse_r <= 2'h0;
      tx_char_r <= URMD_RST_ZERO;
      tx_write_r <= 1'b0;
      rx_read_r <= 1'b0;
      lstat_rd_r <= 1'b0;
      mstat_rd_r <= 1'b0;
      istat_rd_r <= 1'b0;
    end else if (i_ce) begin
      if (rd_act) begin
        rdata_r <= rdata_nxt;
      end
      fctl_r <= fctl_nxt;
      fifo_pulse_r <= (wr_act && we_fctl) ? i_wdata[2:1] : 2'h0;
      if (wr_act && we_tx) begin
        tx_char_r <= i_wdata;
      end
      tx_write_r <= wr_act && we_tx;
      rx_read_r <= rd_act && rd_rx;
      lstat_rd_r <= rd_act && rd_lstat;
      mstat_rd_r <= rd_act && rd_mstat;
      istat_rd_r <= rd_act && rd_istat;
    end
  end

  assign o_rdata = rdata_r;
  assign o_rx_read = rx_read_r;
  assign o_tx_write = tx_write_r;
  assign o_tx_char = tx_char_r;
  assign o_line_status_read = lstat_rd_r;
  assign o_modem_status_read = mstat_rd_r;
  assign o_int_status_read = istat_rd_r;
  assign o_interrupt_enable = ien_view;
  assign o_fifo_control = enh ? fctl_r : (fctl_r & ~URMD_FCTL_ENH_MASK);
  assign o_rx_fifo_reset = fifo_pulse_r[0];
  assign o_tx_fifo_reset = fifo_pulse_r[1];
  assign o_line_control = lctl_q;
  assign o_modem_control = mctl_view;
  assign o_divisor = {div_hi_q, div_lo_q};
  assign o_enhanced_function = efn_q;
  // Extra-feature and pulse-width settings drive nothing outside enhanced mode
  assign o_extra_feature = enh ? xfeat_q : URMD_RST_ZERO;
  assign o_ir_pulse_width = enh ? pwidth_q : URMD_RST_ZERO;
  assign o_resume_char_one = res_one_q;
  assign o_resume_char_two = res_two_q;
  assign o_pause_char_one = pau_one_q;
  assign o_pause_char_two = pau_two_q;
endmodule

// [tb/urmd_engine_model.sv]
// Partner: serial engine model supplying receive data and status
`timescale 1ns/100ps
module urmd_engine_model (
  input wire logic i_clock,
  input wire logic i_read_seen,
  output logic [7:0] o_rx_char,
  output logic [5:0] o_int_source,
  output logic [7:0] o_line_status,
  output logic [7:0] o_modem_status
);
  initial {o_rx_char, o_int_source, o_line_status, o_modem_status} = 30'h1234_5678;
  // Values move one edge after a read strobe, never under a pending read
  always @(posedge i_clock) begin
    if (i_read_seen) begin
      {o_rx_char, o_int_source, o_line_status, o_modem_status} <= 30'($urandom);
    end
  end
endmodule

// [tb/urmd_top_sva.sv]
// Checker: access steering and gating properties of the register decode
`timescale 1ns/100ps
module urmd_top_sva
  import urmd_pkg::*;
#(
  parameter logic [7:0] DEVICE_IDENT = 8'hA5  // Arbitrary value
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic [2:0] i_addr,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic [7:0] i_rx_char,
  input wire logic [7:0] i_line_status,
  input wire logic o_tx_write,
  input wire logic [7:0] o_tx_char,
  input wire logic [7:0] o_interrupt_enable,
  input wire logic [7:0] o_line_control,
  input wire logic [7:0] o_modem_control,
  input wire logic [15:0] o_divisor,
  input wire logic [7:0] o_enhanced_function,
  input wire logic [7:0] o_extra_feature
);
  default clocking cb @(posedge i_clock); endclocking
  // A frozen clock enable holds everything, so it also suspends checking
  default disable iff (!i_rst_n || !i_ce);
  wire [7:0] lc = o_line_control;
  wire en = o_enhanced_function[URMD_EFN_ENH];
  wire base = !lc[URMD_LCTL_DLAB];
  a_tx_write_path: assert property (i_wr && i_addr == 3'h0 && base |=>
    o_tx_write && o_tx_char == $past(i_wdata)) else $error("transmit write lost");
  a_rx_read_path: assert property (i_rd && i_addr == 3'h0 && base |=>
    o_rdata == $past(i_rx_char)) else $error("receive read wrong");
  a_lstat_read_path: assert property (i_rd && i_addr == 3'h5 && base |=>
    o_rdata == $past(i_line_status)) else $error("line status read wrong");
  a_ien_gate_off: assert property (!en |-> o_interrupt_enable[7:4] == 4'h0)
    else $error("interrupt enable high bits leak");
  a_mctl_gate_off: assert property (!en |-> o_modem_control[7:5] == 3'h0)
    else $error("modem control high bits leak");
  a_xfeat_resv_zero: assert property (o_extra_feature[7:6] == 2'h0)
    else $error("reserved bits stored");
  a_lctl_load: assert property (i_wr && i_addr == 3'h3 |=> lc == $past(i_wdata))
    else $error("line control not loaded");
  a_ident_read: assert property (i_rd && i_addr == 3'h1 && !base && lc != 8'hBF &&
    o_divisor == 16'h0000 |=> o_rdata == DEVICE_IDENT) else $error("ident read wrong");
  a_efn_page_load: assert property (i_wr && i_addr == 3'h2 && lc == 8'hBF |=>
    o_enhanced_function == $past(i_wdata)) else $error("enhanced function not loaded");
  a_xfeat_gate_off: assert property (i_wr && i_addr == 3'h5 && base && !en |=>
    $stable(o_extra_feature)) else $error("extra feature written while gated");
  a_xfeat_load: assert property (i_wr && i_addr == 3'h5 && base && en |=>
    o_extra_feature == ($past(i_wdata) & 8'h3F)) else $error("extra feature not loaded");
  c_page2_write: cover property (i_wr && i_addr == 3'h2 && lc == 8'hBF);
  c_ident_read: cover property (i_rd && i_addr == 3'h1 && !base && o_divisor == 16'h0000);
  c_tx_write: cover property (o_tx_write);
endmodule
bind urmd_top urmd_top_sva #(.DEVICE_IDENT(DEVICE_IDENT)) sva_u (.i_clock, .i_rst_n, .i_ce,
  .i_addr, .i_rd, .i_wr, .i_wdata, .o_rdata, .i_rx_char, .i_line_status, .o_tx_write,
  .o_tx_char, .o_interrupt_enable, .o_line_control, .o_modem_control, .o_divisor,
  .o_enhanced_function, .o_extra_feature);

// [tb/urmd_top_tb.sv]
// Testbench: host-side register accesses against the decode block
`timescale 1ns/100ps
module urmd_top_tb;
  import urmd_pkg::*;
  localparam logic [7:0] REV = 8'h5A;  // Arbitrary value
  localparam logic [7:0] IDENT = 8'hA5;  // Arbitrary value
  logic i_clock = 1'b0, i_rst_n = 1'b0, i_ce = 1'b1, i_rd = 1'b0, i_wr = 1'b0, rd_d = 1'b0;
  logic [2:0] i_addr = 3'h0;
  logic [7:0] i_wdata = 8'h00, d, o_rdata, o_tx_char, o_interrupt_enable, o_fifo_control;
  logic [7:0] o_line_control, o_modem_control, o_enhanced_function, o_extra_feature;
  logic [7:0] o_ir_pulse_width, o_resume_char_one, o_resume_char_two, o_pause_char_one;
  logic [7:0] o_pause_char_two, i_rx_char, i_line_status, i_modem_status, c[8];
  logic [5:0] i_int_source;
  logic [15:0] o_divisor;
  logic o_rx_read, o_tx_write, o_line_status_read, o_modem_status_read, o_int_status_read;
  logic o_rx_fifo_reset, o_tx_fifo_reset;
  logic [7:0] exp_q[$];
  logic [15:0] n_strb = 16'h0000;
  int errors = 0, num_checks = 0, i;
  wire seen = o_rx_read | o_line_status_read | o_modem_status_read | o_int_status_read;
  always #10 i_clock = ~i_clock;
  urmd_top #(.REVISION_CODE(REV), .DEVICE_IDENT(IDENT)) dut_u (.i_clock, .i_rst_n, .i_ce,
    .i_addr, .i_rd, .i_wr, .i_wdata, .o_rdata, .i_rx_char, .i_int_source, .i_line_status,
    .i_modem_status, .o_rx_read, .o_tx_write, .o_tx_char, .o_line_status_read,
    .o_modem_status_read, .o_int_status_read, .o_interrupt_enable, .o_fifo_control,
    .o_rx_fifo_reset, .o_tx_fifo_reset, .o_line_control, .o_modem_control, .o_divisor,
    .o_enhanced_function, .o_extra_feature, .o_ir_pulse_width, .o_resume_char_one,
    .o_resume_char_two, .o_pause_char_one, .o_pause_char_two);
  urmd_engine_model eng_u (.i_clock, .i_read_seen(seen), .o_rx_char(i_rx_char),
    .o_int_source(i_int_source), .o_line_status(i_line_status),
    .o_modem_status(i_modem_status));
  task automatic check_port(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic check_rd(input logic [7:0] g, input logic [7:0] e);
    check_port({8'h00, g}, {8'h00, e});
  endtask
  task automatic complete_run();
    if (exp_q.size() != 0) errors++;
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(negedge i_clock);
    {i_addr, i_wdata, i_wr} = {a, v, 1'b1};
    @(negedge i_clock);
    i_wr = 1'b0;
  endtask
  // Extra idle cycle lets the engine model settle before the next expectation
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(negedge i_clock);
    {i_addr, i_rd} = {a, 1'b1};
    exp_q.push_back(e);
    @(negedge i_clock);
    i_rd = 1'b0;
    @(negedge i_clock);
  endtask
  always @(posedge i_clock) rd_d <= i_rd & i_rst_n;
  // One nibble per strobe kind, so a strobe of the wrong kind shows in the total
  always @(negedge i_clock) n_strb <= n_strb + {o_int_status_read, 3'h0, o_modem_status_read,
    3'h0, o_line_status_read, 3'h0, o_rx_read};
  always @(negedge i_clock) begin
    if (rd_d) check_rd(o_rdata, exp_q.pop_front());
  end
  initial begin
    repeat (5000) @(posedge i_clock);
    errors++;
    complete_run();
  end
  initial begin
    void'($urandom(38));
    repeat (8) @(negedge i_clock);
    i_rst_n = 1'b1;
    wr(URMD_A_IEN, 8'hFF); check_port(o_interrupt_enable, 16'h000F);
    rd(URMD_A_IEN, 8'h0F);
    wr(URMD_A_MCTL, 8'hFF); check_port(o_modem_control, 16'h001F);
    wr(URMD_A_ISTAT, 8'hF7);
    check_port({o_rx_fifo_reset, o_tx_fifo_reset, o_fifo_control}, 16'h03C1);
    rd(URMD_A_ISTAT, {4'hC, i_int_source[3:0]});
    rd(URMD_A_DATA, i_rx_char);
    d = 8'($urandom);
    wr(URMD_A_DATA, d); check_port({o_tx_write, o_tx_char}, {7'h00, 1'b1, d});
    rd(URMD_A_LSTAT, i_line_status);
    rd(URMD_A_MSTAT, i_modem_status & 8'h0F);
    wr(URMD_A_LSTAT, 8'hFF); check_port(o_extra_feature, 16'h0000);
    wr(URMD_A_MSTAT, 8'h77); check_port(o_ir_pulse_width, 16'h0000);
    wr(URMD_A_SCR, d); rd(URMD_A_SCR, d);
    i_ce = 1'b0;
    wr(URMD_A_SCR, ~d);
    i_ce = 1'b1;
    rd(URMD_A_SCR, d);
    d = 8'($urandom) & 8'h7F;
    wr(URMD_A_LCTL, d); rd(URMD_A_LCTL, d);
    wr(URMD_A_LCTL, 8'h80); rd(URMD_A_DATA, REV); rd(URMD_A_IEN, IDENT);
    d = 8'($urandom) | 8'h01;
    wr(URMD_A_DATA, d); wr(URMD_A_IEN, ~d); rd(URMD_A_DATA, d); rd(URMD_A_IEN, ~d);
    check_port(o_divisor, {~d, d});
    wr(URMD_A_LCTL, URMD_PAGE2_KEY); wr(URMD_A_ISTAT, 8'h10); rd(URMD_A_ISTAT, 8'h10);
    for (i = 4; i < 8; i++) begin
      c[i] = 8'($urandom);
      wr(3'(i), c[i]); rd(3'(i), c[i]);
    end
    check_port({o_resume_char_one, o_resume_char_two}, {c[4], c[5]});
    check_port({o_pause_char_one, o_pause_char_two}, {c[6], c[7]});
    wr(URMD_A_LCTL, 8'h03);
    check_port({o_interrupt_enable, o_fifo_control}, 16'h0FC1);
    check_port({o_extra_feature, o_ir_pulse_width}, 16'h0000);
    rd(URMD_A_MCTL, 8'h1F);
    wr(URMD_A_IEN, 8'hFF); check_port(o_interrupt_enable, 16'h00FF);
    wr(URMD_A_LSTAT, 8'hFF); check_port(o_extra_feature, 16'h003F);
    wr(URMD_A_MSTAT, d); check_port(o_ir_pulse_width, {8'h00, d});
    rd(URMD_A_MSTAT, i_modem_status);
    wr(URMD_A_ISTAT, 8'h31); check_port(o_fifo_control, 16'h0031);
    rd(URMD_A_ISTAT, {2'b11, i_int_source});
    check_port(n_strb, 16'h2211);
    i_rst_n = 1'b0;
    repeat (2) @(negedge i_clock);
    i_rst_n = 1'b1;
    check_port(o_divisor, 16'h0000);
    check_port({o_enhanced_function, o_line_control}, 16'h0000);
    repeat (4) @(negedge i_clock);
    complete_run();
  end
endmodule
